// ==== logic/port_override_pkg.sv ====
// Purpose: Constants for the port pin override block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses, except OFF_MCU_CONTROL_IDX, which is a word index
package port_override_pkg;
    localparam int          ADDR_W          = 8;
    // Control register index counts words: byte address is four times it
    localparam logic [7:0]  OFF_MCU_CONTROL = 8'hD4;
    localparam logic [7:0]  OFF_PORT_OUT    = 8'h00;
    localparam logic [7:0]  OFF_PORT_DIR    = 8'h04;
    localparam logic [7:0]  OFF_PORT_PIN    = 8'h08;
    localparam logic [7:0]  OFF_SLEEP_CTL   = 8'h0C;
    localparam logic [7:0]  OFF_MCU_CONTROL_IDX = 8'h35;
    localparam logic [7:0]  MCU_CONTROL_RST = 8'h00;
    localparam logic [7:0]  MCU_CONTROL_WMASK = 8'h93;
    localparam int          BIT_PUD         = 4;
    localparam int          BIT_DEBUG_DIS   = 7;
    localparam int          BIT_VEC_SEL     = 1;
    localparam int          BIT_VEC_CHG     = 0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ==== logic/port_pin_alternate_override.sv ====
// Purpose: One I/O port with alternate function override muxes and control regs
// Assumes: Pad level arrives asynchronously; override signals are same-clock logic
// Notes:   Registers on AXI4-Lite; pull-ups forced off while reset is held
//
// Functional notes
// - Pull-up override enable set: pull-up follows override value only.
// - Otherwise pull-up on only when direction=0, output bit=1, global disable=0.
// - Driver enable follows direction override value when enabled, else direction bit.
// - Direction override value one enables driver, zero disables it.
// - Value override enabled: driven level is the override value.
// - Value override disabled: driven level is the output register bit.
// - Value override enabled: driven level equals override value regardless of output register bit.
// - Toggle override enable inverts the output register bit.
// - Input enable override enable set: input enable is the override value.
// - Otherwise input enable is on when awake, off in clamping sleep.
// - Input override value one enables input, zero disables, any sleep state.
// - Alternate functions receive the raw, unsynchronised gated input.
// - Analog path ties straight to the pad, usable both ways.
// - Pull-ups are held off during reset.
// - Strobes are per port; clock, sleep and global disable are shared.
// - Control register resets to zero, disable in bit 4, bits 7,4,1,0 writable.
// - Global disable turns off pull-ups requested by direction and output bits.
// - Direction bit one makes pin an output, zero an input.
// - Writing one to pin input bit toggles the output bit.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module port_pin_alternate_override #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // AXI4-Lite write address, data and response
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Sleep controller clamp request, shared by all ports
    input  wire logic                 sleepClamp,
    // Alternate-function overrides, one bit per pin
    input  wire logic [PIN_COUNT-1:0] pullupOverrideEn,
    input  wire logic [PIN_COUNT-1:0] pullupOverrideVal,
    input  wire logic [PIN_COUNT-1:0] dirOverrideEn,
    input  wire logic [PIN_COUNT-1:0] dirOverrideVal,
    input  wire logic [PIN_COUNT-1:0] valueOverrideEn,
    input  wire logic [PIN_COUNT-1:0] valueOverrideVal,
    input  wire logic [PIN_COUNT-1:0] toggleOverrideEn,
    input  wire logic [PIN_COUNT-1:0] inputEnableOverrideEn,
    input  wire logic [PIN_COUNT-1:0] inputEnableOverrideVal,
    // Pads: input level and drive controls (oe low drives)
    input  wire logic [PIN_COUNT-1:0] padIn,
    output logic      [PIN_COUNT-1:0] padOut,
    output logic      [PIN_COUNT-1:0] padOe_b,
    output logic      [PIN_COUNT-1:0] padPullup,
    // To alternate functions
    output logic      [PIN_COUNT-1:0] rawDigitalIn,
    output logic      [PIN_COUNT-1:0] digitalInEnable,
    // Control register bits for other blocks
    output logic                      globalPullupDisable,
    output logic                      debugPortDisable,
    output logic                      vectorTableSelect,
    output logic                      vectorChangeEnable
);
    // Elaboration check on the pin count
    if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : gBadPinCount
        $error("PIN_COUNT must be 1..8");
    end

    logic                 rstMeta;
    logic                 rstSync;
    logic [7:0]           mcuControl;
    logic [PIN_COUNT-1:0] pinOutputBit;
    logic [PIN_COUNT-1:0] pinDirectionBit;
    logic [PIN_COUNT-1:0] padMeta;
    logic [PIN_COUNT-1:0] pinInputBit;
    logic [PIN_COUNT-1:0] driverEn;
    logic                 wrFire;
    logic                 awHeld;
    logic                 wHeld;
    logic [7:0]           awAddrHeld;
    logic [31:0]          wDataHeld;
    logic [3:0]           wStrbHeld;
    logic [7:0]           wrAddr;
    logic [31:0]          wrData;
    logic                 wrLane0;
    logic                 portOutWriteStrobe;
    logic                 pinToggleWriteStrobe;
    logic                 dirWriteStrobe;
    logic                 ctlWriteStrobe;

    // Map an address to its register; unmapped decodes as not valid
    function automatic logic addrMapped(input logic [7:0] a);
        addrMapped = (a == port_override_pkg::OFF_PORT_OUT) ||
                     (a == port_override_pkg::OFF_PORT_DIR) ||
                     (a == port_override_pkg::OFF_PORT_PIN) ||
                     (a == port_override_pkg::OFF_MCU_CONTROL);
    endfunction

    // Reset release synchroniser
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Write channel capture, address and data in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign wrAddr  = awHeld ? awAddrHeld : s_axi_awaddr;
    assign wrData  = wHeld ? wDataHeld : s_axi_wdata;
    assign wrLane0 = wHeld ? wStrbHeld[0] : s_axi_wstrb[0];
    assign wrFire  = (awHeld || (s_axi_awvalid && s_axi_awready)) &&
                     (wHeld || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            awHeld     <= 1'b0;
            wHeld      <= 1'b0;
            awAddrHeld <= 8'h00;
            wDataHeld  <= 32'h0000_0000;
            wStrbHeld  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= port_override_pkg::RESP_OKAY;
        end else begin
            if (wrFire) begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addrMapped(wrAddr) ? port_override_pkg::RESP_OKAY
                                                   : port_override_pkg::RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld     <= 1'b1;
                    awAddrHeld <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld     <= 1'b1;
                    wDataHeld <= s_axi_wdata;
                    wStrbHeld <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Port-wide write strobes, shared by all pins of the port
    assign portOutWriteStrobe   = wrFire && wrLane0 &&
                                  (wrAddr == port_override_pkg::OFF_PORT_OUT);
    assign pinToggleWriteStrobe = wrFire && wrLane0 &&
                                  (wrAddr == port_override_pkg::OFF_PORT_PIN);
    assign dirWriteStrobe       = wrFire && wrLane0 &&
                                  (wrAddr == port_override_pkg::OFF_PORT_DIR);
    assign ctlWriteStrobe       = wrFire && wrLane0 &&
                                  (wrAddr == port_override_pkg::OFF_MCU_CONTROL);

    // Control register, only writable bits change
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            mcuControl <= port_override_pkg::MCU_CONTROL_RST;
        end else if (ctlWriteStrobe) begin
            mcuControl <= wrData[7:0] & port_override_pkg::MCU_CONTROL_WMASK;
        end
    end
    assign globalPullupDisable = mcuControl[port_override_pkg::BIT_PUD];
    assign debugPortDisable    = mcuControl[port_override_pkg::BIT_DEBUG_DIS];
    assign vectorTableSelect   = mcuControl[port_override_pkg::BIT_VEC_SEL];
    assign vectorChangeEnable  = mcuControl[port_override_pkg::BIT_VEC_CHG];

    // Direction register
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            pinDirectionBit <= '0;
        end else if (dirWriteStrobe) begin
            pinDirectionBit <= wrData[PIN_COUNT-1:0];
        end
    end

    // Output register: write, pin-bit toggle and alternate toggle
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            pinOutputBit <= '0;
        end else if (portOutWriteStrobe) begin
            pinOutputBit <= wrData[PIN_COUNT-1:0] ^ toggleOverrideEn;
        end else begin
            pinOutputBit <= pinOutputBit ^ toggleOverrideEn ^
                (pinToggleWriteStrobe ? wrData[PIN_COUNT-1:0] : '0);
        end
    end

    // Per-pin override muxes, purely combinational
    // Analog path joins the pad outside these muxes, usable both ways
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : gPin
            assign driverEn[gi] = dirOverrideEn[gi] ? dirOverrideVal[gi]
                                                    : pinDirectionBit[gi];
            assign padOe_b[gi]  = !driverEn[gi];
            assign padOut[gi]   = valueOverrideEn[gi] ? valueOverrideVal[gi]
                                                      : pinOutputBit[gi];
            assign padPullup[gi] = rstSync && (pullupOverrideEn[gi]
                ? pullupOverrideVal[gi]
                : ({pinDirectionBit[gi], pinOutputBit[gi], globalPullupDisable}
                   == 3'b010));
            assign digitalInEnable[gi] = inputEnableOverrideEn[gi]
                ? inputEnableOverrideVal[gi]
                : !sleepClamp;
            // Clamped level after the input stage, unsynchronised
            assign rawDigitalIn[gi] = padIn[gi] && digitalInEnable[gi];
        end
    endgenerate

    // Pin read synchroniser
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            padMeta     <= '0;
            pinInputBit <= '0;
        end else begin
            padMeta     <= rawDigitalIn;
            pinInputBit <= padMeta;
        end
    end

    // Read channel, one read under way
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= port_override_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= port_override_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
                port_override_pkg::OFF_PORT_OUT:
                    s_axi_rdata[PIN_COUNT-1:0] <= pinOutputBit;
                port_override_pkg::OFF_PORT_DIR:
                    s_axi_rdata[PIN_COUNT-1:0] <= pinDirectionBit;
                port_override_pkg::OFF_PORT_PIN:
                    s_axi_rdata[PIN_COUNT-1:0] <= pinInputBit;
                port_override_pkg::OFF_MCU_CONTROL:
                    s_axi_rdata[7:0] <= mcuControl;
                default:
                    s_axi_rresp <= port_override_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    AST_PULLUP_OVR: assert property (@(posedge core_clk) disable iff (!rstSync)
        pullupOverrideEn[0] |-> padPullup[0] == pullupOverrideVal[0])
        else $error("pull-up ignores override");
    AST_PULLUP_REG: assert property (@(posedge core_clk) disable iff (!rstSync)
        !pullupOverrideEn[0] |-> padPullup[0] == (!pinDirectionBit[0] &&
            pinOutputBit[0] && !globalPullupDisable))
        else $error("pull-up decode wrong");
    AST_PUD_OFF: assert property (@(posedge core_clk) disable iff (!rstSync)
        (globalPullupDisable && !pullupOverrideEn[0]) |-> !padPullup[0])
        else $error("global disable ignored");
    AST_DRIVER: assert property (@(posedge core_clk) disable iff (!rstSync)
        padOe_b[0] == !(dirOverrideEn[0] ? dirOverrideVal[0] : pinDirectionBit[0]))
        else $error("driver enable wrong");
    AST_VALUE: assert property (@(posedge core_clk) disable iff (!rstSync)
        valueOverrideEn[0] |-> padOut[0] == valueOverrideVal[0])
        else $error("value override ignored");
    AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!rstSync)
        (toggleOverrideEn[0] && !portOutWriteStrobe && !pinToggleWriteStrobe)
        |=> pinOutputBit[0] != $past(pinOutputBit[0]))
        else $error("toggle missed");
    AST_DIE: assert property (@(posedge core_clk) disable iff (!rstSync)
        digitalInEnable[0] == (inputEnableOverrideEn[0] ?
            inputEnableOverrideVal[0] : !sleepClamp))
        else $error("input enable wrong");
    AST_CTL_MASK: assert property (@(posedge core_clk) disable iff (!rstSync)
        ctlWriteStrobe |=> mcuControl ==
            ($past(wrData[7:0]) & port_override_pkg::MCU_CONTROL_WMASK))
        else $error("control write mask wrong");
    AST_RST_PULLUP: assert property (@(posedge core_clk)
        !rstSync |-> padPullup == '0)
        else $error("pull-up during reset");
endmodule

// ==== test/alt_function_model.sv ====
// Purpose: Stand-in for the alternate-function modules beside one port
// Assumes: Bench supplies the override pattern as one 72-bit word
// Notes:   Toggle request only lasts while load is high
`timescale 1ns/1ps
module alt_function_model (
    // Clock
    input  wire logic        core_clk,
    // Override pattern from the bench
    input  wire logic        load,
    input  wire logic [71:0] ctl,
    // Raw level back from the port
    input  wire logic [7:0]  rawDigitalIn,
    // Override levels to the port
    output logic      [7:0]  pullupOverrideEn,
    output logic      [7:0]  pullupOverrideVal,
    output logic      [7:0]  dirOverrideEn,
    output logic      [7:0]  dirOverrideVal,
    output logic      [7:0]  valueOverrideEn,
    output logic      [7:0]  valueOverrideVal,
    output logic      [7:0]  toggleOverrideEn,
    output logic      [7:0]  inputEnableOverrideEn,
    output logic      [7:0]  inputEnableOverrideVal,
    // Own synchronised copy of the raw input
    output logic      [7:0]  syncIn
);
    logic [7:0] syncMid;
    // Override levels other than toggle stand as long as the pattern does
    assign pullupOverrideEn = ctl[7:0];
    assign pullupOverrideVal = ctl[15:8];
    assign dirOverrideEn = ctl[23:16];
    assign dirOverrideVal = ctl[31:24];
    assign valueOverrideEn = ctl[39:32];
    assign valueOverrideVal = ctl[47:40];
    assign toggleOverrideEn = ctl[55:48] & {8{load}};  // One pulse per load
    assign inputEnableOverrideEn = ctl[63:56];
    assign inputEnableOverrideVal = ctl[71:64];
    // Two stages guard against metastable pad edges
    always_ff @(posedge core_clk) begin
        syncMid <= rawDigitalIn;
        syncIn <= syncMid;
    end
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the port override block
// Assumes: AXI4-Lite master tasks start after a rising edge
// Notes:   Bus results checked from queues at the falling edge
`timescale 1ns/1ps
module tb;
    logic        core_clk, rst_b, load, sleepClamp, inRst, epud;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, padIn, eo, edir, ectl;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, seed;
    logic [3:0]  s_axi_wstrb;
    logic [71:0] ctl;
    logic [33:0] rexp;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  pullupOverrideEn, pullupOverrideVal, dirOverrideEn, dirOverrideVal;
    wire logic [7:0]  valueOverrideEn, valueOverrideVal, toggleOverrideEn, syncIn;
    wire logic [7:0]  inputEnableOverrideEn, inputEnableOverrideVal, padOut, padOe_b;
    wire logic [7:0]  padPullup, rawDigitalIn, digitalInEnable;
    wire logic        globalPullupDisable;
    wire logic        debugPortDisable, vectorTableSelect, vectorChangeEnable;
    int          bad_count, compares;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    // Device under test and the far-side model
    port_pin_alternate_override port_pin_alternate_override_i (.core_clk, .rst_b,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleepClamp, .pullupOverrideEn, .pullupOverrideVal,
        .dirOverrideEn, .dirOverrideVal, .valueOverrideEn, .valueOverrideVal,
        .toggleOverrideEn, .inputEnableOverrideEn, .inputEnableOverrideVal, .padIn,
        .padOut, .padOe_b, .padPullup, .rawDigitalIn, .digitalInEnable,
        .globalPullupDisable, .debugPortDisable, .vectorTableSelect,
        .vectorChangeEnable);
    alt_function_model alt_function_model_i (.core_clk, .load, .ctl, .rawDigitalIn,
        .pullupOverrideEn, .pullupOverrideVal, .dirOverrideEn, .dirOverrideVal,
        .valueOverrideEn, .valueOverrideVal, .toggleOverrideEn, .inputEnableOverrideEn,
        .inputEnableOverrideVal, .syncIn);
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Expected pad controls from the bench's own register copy
    task automatic chk_pins;
        logic [7:0] pu, drv, die;
        pu = (ctl[7:0] & ctl[15:8]) | (~ctl[7:0] & ~edir & eo & {8{~epud}});
        drv = (ctl[23:16] & ctl[31:24]) | (~ctl[23:16] & edir);
        die = (ctl[63:56] & ctl[71:64]) | (~ctl[63:56] & {8{~sleepClamp}});
        chk_pin("pullup", inRst ? 8'h00 : pu, padPullup);
        if (!inRst) begin
            chk_pin("oe_b", ~drv, padOe_b);
            chk_pin("out", ((ctl[39:32] & ctl[47:40]) | (~ctl[39:32] & eo)) & drv,
                    padOut & drv);
            chk_pin("die", die, digitalInEnable);
            chk_pin("raw", padIn & die, rawDigitalIn);
            chk_pin("pud", {7'h00, epud}, {7'h00, globalPullupDisable});
            chk_pin("ctl", {5'h00, ectl[7], ectl[1:0]}, {5'h00, debugPortDisable,
                    vectorTableSelect, vectorChangeEnable});
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, b;
        @(posedge core_clk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge core_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge core_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
        logic ar, rv;
        @(posedge core_clk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rv = 1'b0;
        while (!rv) begin
            @(negedge core_clk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            @(posedge core_clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    // Responses taken off the queues as they appear
    always @(negedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            chk_bus("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rexp = rq.pop_front();
            chk_bus("rresp", {30'h0, rexp[33:32]}, {30'h0, s_axi_rresp});
            chk_bus("rdata", rexp[31:0], s_axi_rdata);
        end
    end
    task finish_test;
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        finish_test;
    end
    initial begin
        {rst_b, load, sleepClamp, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
        {s_axi_arvalid, s_axi_rready, epud, inRst} = 4'h1;
        {s_axi_awaddr, s_axi_araddr, padIn, eo, edir, ectl} = 48'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        ctl = 72'hFFFF;
        seed = 32'hE8C0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) chk_pins;
        @(posedge core_clk) rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        inRst = 1'b0;
        axi_read(port_override_pkg::OFF_MCU_CONTROL, 34'h0);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            ctl[31:0] <= seed;
            seed = lfsr(seed);
            ctl[63:32] <= seed;
            padIn <= seed[15:8];
            seed = lfsr(seed);
            ctl[71:64] <= seed[7:0];
            sleepClamp <= seed[8];
            load <= 1'b1;
            @(negedge core_clk) chk_pins;
            @(posedge core_clk) load <= 1'b0;
            eo = eo ^ ctl[55:48];
            @(negedge core_clk) chk_pins;
            seed = lfsr(seed);
            axi_write(port_override_pkg::OFF_PORT_OUT, seed, 2'h0);
            eo = seed[7:0];
            axi_write(port_override_pkg::OFF_PORT_DIR, seed >> 8, 2'h0);
            edir = seed[15:8];
            axi_write(port_override_pkg::OFF_PORT_PIN, seed >> 16, 2'h0);
            eo = eo ^ seed[23:16];
            axi_write(port_override_pkg::OFF_MCU_CONTROL, seed, 2'h0);
            epud = seed[4];
            ectl = seed[7:0] & port_override_pkg::MCU_CONTROL_WMASK;
            @(negedge core_clk) chk_pins;
            axi_read(port_override_pkg::OFF_PORT_OUT, {26'h0, eo});
            axi_read(port_override_pkg::OFF_PORT_DIR, {26'h0, edir});
            axi_read(port_override_pkg::OFF_MCU_CONTROL, {26'h0, seed[7:0] & 8'h93});
        end
        // Unmapped place, then pin reads awake and clamped
        axi_write(8'h40, 32'hFF, 2'h2);
        axi_read(8'h40, {2'h2, 32'h0});
        ctl <= 72'h0;
        sleepClamp <= 1'b0;
        padIn <= 8'hA5;
        repeat (3) @(posedge core_clk);
        chk_pin("sync", 8'hA5, syncIn);
        axi_read(port_override_pkg::OFF_PORT_PIN, {26'h0, 8'hA5});
        sleepClamp <= 1'b1;
        repeat (3) @(posedge core_clk);
        axi_read(port_override_pkg::OFF_PORT_PIN, 34'h0);
        // Pull-ups requested by software, then a reset in mid-run
        axi_write(port_override_pkg::OFF_MCU_CONTROL, 32'h0, 2'h0);
        axi_write(port_override_pkg::OFF_PORT_DIR, 32'h0, 2'h0);
        axi_write(port_override_pkg::OFF_PORT_OUT, 32'hFF, 2'h0);
        {eo, edir, epud, ectl} = 25'h1FE0000;
        @(negedge core_clk) chk_pins;
        @(posedge core_clk) rst_b <= 1'b0;
        inRst = 1'b1;
        @(negedge core_clk) chk_pins;
        @(posedge core_clk) rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        {eo, inRst} = 9'h0;
        @(negedge core_clk) chk_pins;
        axi_read(port_override_pkg::OFF_MCU_CONTROL, 34'h0);
        repeat (4) @(posedge core_clk);
        finish_test;
    end
endmodule
